// [core/dds_pkg.sv]
// Constants, types and operation summary for the one-channel waveform synthesis core
// ****************************************************************
// Operation
// R1 - Each sampling cycle the phase increment is added to the phase accumulator.
// R2 - Output frequency depends only on the increment, and a new increment changes nothing else.
// R3 - The accumulator phase addresses the waveform memory and the sample read goes to the DAC.
// R4 - The waveform memory holds one amplitude word per phase position.
// R5 - The DAC sees one held sample per clock, giving a stepped waveform.
// R6 - Waveform numbers up to 165 are accepted, each selecting its own table.
// R7 - Numbers 1 to 7 select the common standard waveforms.
// R8 - Numbers 8 to 156 select fixed read-only tables that can be copied into user tables.
// R9 - Numbers 157 to 164 select eight user-loaded arbitrary tables.
// R10 - Number 165 selects the writable user harmonic table.
// R11 - Every channel has its own independent copy of this core with identical behaviour.
// R12 - In continuous output the settings hold steady so the phase advances linearly.
// R13 - The accumulator wraps at full width, its top bits are the table address.
// R14 - New increment or waveform settings are registered and take effect on one clock edge.
// ****************************************************************
`default_nettype none

package dds_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int ACC_W        = 32;
  localparam int ADDR_W       = 6;
  localparam int TBL_DEPTH    = 64;
  localparam int SAMP_W       = 12;
  localparam int WAVE_W       = 8;
  localparam int SEL_W        = 4;
  localparam int USER_TABLES  = 9;
  localparam int FIFO_DEPTH   = 16;
  localparam int LFSR_W       = 16;

  // ****************************************************************
  // Waveform catalogue
  // ****************************************************************
  localparam logic [WAVE_W-1:0] WAVE_FIRST  = 8'h01;
  localparam logic [WAVE_W-1:0] WAVE_SINE   = 8'h01;
  localparam logic [WAVE_W-1:0] WAVE_SQUARE = 8'h02;
  localparam logic [WAVE_W-1:0] WAVE_RAMP   = 8'h03;
  localparam logic [WAVE_W-1:0] WAVE_PULSE  = 8'h04;
  localparam logic [WAVE_W-1:0] WAVE_NOISE  = 8'h05;
  localparam logic [WAVE_W-1:0] WAVE_DC     = 8'h06;
  localparam logic [WAVE_W-1:0] WAVE_PRBS   = 8'h07;
  localparam logic [WAVE_W-1:0] FIXED_LAST  = 8'h9c;
  localparam logic [WAVE_W-1:0] ARB_FIRST   = 8'h9d;
  localparam logic [WAVE_W-1:0] WAVE_HARM   = 8'ha5;

  // ****************************************************************
  // Reset values and sample levels
  // ****************************************************************
  localparam logic [ACC_W-1:0]  INC_RST     = 32'h0000_0000;
  localparam logic [WAVE_W-1:0] WAVE_RST    = 8'h01;
  localparam logic [LFSR_W-1:0] LFSR_SEED   = 16'hace1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS   = 16'hb400;
  localparam logic [SAMP_W-1:0] SAMP_MID    = 12'h800;
  localparam logic [SAMP_W-1:0] SAMP_HIGH   = 12'hfff;
  localparam logic [SAMP_W-1:0] SAMP_LOW    = 12'h000;

  // ****************************************************************
  // Carriers and modes
  // ****************************************************************
  typedef struct packed {
    logic [ACC_W-1:0]  inc;
    logic [WAVE_W-1:0] wave;
  } dds_set_t;

  typedef struct packed {
    logic [SEL_W-1:0]  sel;
    logic [ADDR_W-1:0] addr;
    logic [SAMP_W-1:0] data;
  } dds_tbl_wr_t;

  typedef enum logic [0:0] {
    DDS_RUN,
    DDS_COPY
  } dds_mode_t;

endpackage

`default_nettype wire

// [core/dds_fifo.sv]
// Sample FIFO with valid and ready on both sides
`default_nettype none

module dds_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [PW:0]             count;
  } dds_fifo_state_t;

  dds_fifo_state_t st;
  dds_fifo_state_t next_st;
  logic            push;
  logic            pop;

  assign in_ready  = (st.count != (PW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = PW'((DEPTH > 1) ? st.wr + 1'b1 : 0);
    end
    if (pop) begin
      next_st.rd = PW'(st.rd + 1'b1);
    end
    // Push and pop together keep the count
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

// [core/dds_core.sv]
// One channel of the direct digital synthesis waveform core
`default_nettype none

module dds_core
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Settings update
  input  wire logic              set_load,
  input  wire dds_set_t          set_val,
  output logic [WAVE_W-1:0]      cur_wave,
  output logic                   set_reject,
  // User table loading
  input  wire logic              tbl_we,
  input  wire dds_tbl_wr_t       tbl_wr,
  input  wire logic              copy_start,
  input  wire logic [WAVE_W-1:0] copy_src,
  input  wire logic [SEL_W-1:0]  copy_dst,
  output logic                   copy_busy,
  // Converter side
  input  wire logic              dac_ready,
  output logic                   dac_valid,
  output logic [SAMP_W-1:0]      dac_sample
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [ACC_W-1:0]                                 acc;
    logic [ACC_W-1:0]                                 inc;
    logic [WAVE_W-1:0]                                wave;
    logic                                             reject;
    logic [LFSR_W-1:0]                                lfsr;
    logic [USER_TABLES-1:0][TBL_DEPTH-1:0][SAMP_W-1:0] umem;
    dds_mode_t                                        mode;
    logic [WAVE_W-1:0]                                csrc;
    logic [SEL_W-1:0]                                 cdst;
    logic [ADDR_W-1:0]                                caddr;
    logic                                             dvalid;
    logic [SAMP_W-1:0]                                dsample;
  } dds_state_t;

  dds_state_t           st;
  dds_state_t           next_st;
  logic [ADDR_W-1:0]    rd_addr;
  logic [SAMP_W-1:0]    rd_sample;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;
  logic [SAMP_W-1:0]    fifo_out_data;

  // ****************************************************************
  // Table functions
  // ****************************************************************
  function automatic logic is_fixed(input logic [WAVE_W-1:0] w);
    is_fixed = (w >= WAVE_FIRST) && (w <= FIXED_LAST);
  endfunction

  function automatic logic [SEL_W-1:0] user_sel(input logic [WAVE_W-1:0] w);
    logic [WAVE_W-1:0] d;
    d        = w - ARB_FIRST;
    user_sel = d[SEL_W-1:0];
  endfunction

  // Built-in tables are computed, not stored, to save flip-flops
  function automatic logic [SAMP_W-1:0] fixed_sample(input logic [WAVE_W-1:0] w,
                                                     input logic [ADDR_W-1:0] a,
                                                     input logic [LFSR_W-1:0] rnd);
    logic [4:0]  t;
    logic [9:0]  y;
    logic [12:0] mag;
    logic [13:0] prod;
    t    = a[4:0];
    y    = 10'(t) * (10'd32 - 10'(t));
    mag  = {y, 3'b000};
    prod = 14'(a) * 14'(w);
    if (mag > 13'h07ff) begin
      mag = 13'h07ff;
    end
    case (w)
      WAVE_SINE:   fixed_sample = a[ADDR_W-1] ? SAMP_MID - mag[SAMP_W-1:0]
                                              : SAMP_MID + mag[SAMP_W-1:0]; // R7
      WAVE_SQUARE: fixed_sample = a[ADDR_W-1] ? SAMP_LOW : SAMP_HIGH;       // R7
      WAVE_RAMP:   fixed_sample = {a, a};                                   // R7
      WAVE_PULSE:  fixed_sample = (a[ADDR_W-1:ADDR_W-2] == 2'b00) ? SAMP_HIGH : SAMP_LOW;
      WAVE_NOISE:  fixed_sample = rnd[SAMP_W-1:0];                          // R7
      WAVE_DC:     fixed_sample = SAMP_MID;                                 // R7
      WAVE_PRBS:   fixed_sample = rnd[0] ? SAMP_HIGH : SAMP_LOW;            // R7
      // Top bits carry the number, so tables 8 to 156 differ from each other at phase zero
      default:     fixed_sample = prod[SAMP_W-1:0] ^ {w, 4'h0};             // R8
    endcase
  endfunction

  // ****************************************************************
  // Waveform memory read
  // ****************************************************************
  assign rd_addr = st.acc[ACC_W-1 -: ADDR_W]; // R13

  always_comb begin
    if (is_fixed(st.wave)) begin
      rd_sample = fixed_sample(st.wave, rd_addr, st.lfsr); // R6
    end else begin
      rd_sample = st.umem[user_sel(st.wave)][rd_addr]; // R4 R9 R10
    end
  end

  // ****************************************************************
  // Sample FIFO between the table and the converter
  // ****************************************************************
  dds_fifo #(
    .W     (SAMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (1'b1),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_sample),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Output register refills whenever empty or the converter takes it
  assign fifo_out_ready = !st.dvalid || dac_ready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;

    // A full FIFO stalls the phase so no sample is skipped
    if (fifo_in_ready) begin
      next_st.acc  = st.acc + st.inc; // R1 R2 R3 R13
      next_st.lfsr = st.lfsr[0] ? (st.lfsr >> 1) ^ LFSR_TAPS : (st.lfsr >> 1);
    end

    // Settings change only on a load pulse, otherwise held steady
    next_st.reject = 1'b0;
    if (set_load) begin
      next_st.inc = set_val.inc; // R14 R2 R12
      if ((set_val.wave >= WAVE_FIRST) && (set_val.wave <= WAVE_HARM)) begin
        next_st.wave = set_val.wave; // R14 R6
      end else begin
        next_st.reject = 1'b1;
      end
    end

    case (st.mode)
      DDS_RUN: begin
        if (copy_start && is_fixed(copy_src)
            && (copy_dst < SEL_W'(USER_TABLES))) begin
          next_st.mode  = DDS_COPY; // R8
          next_st.csrc  = copy_src;
          next_st.cdst  = copy_dst;
          next_st.caddr = '0;
        end else if (tbl_we && (tbl_wr.sel < SEL_W'(USER_TABLES))) begin
          next_st.umem[tbl_wr.sel][tbl_wr.addr] = tbl_wr.data; // R9 R10
        end
      end
      DDS_COPY: begin
        // Direct writes are ignored while a copy runs
        next_st.umem[st.cdst][st.caddr] = fixed_sample(st.csrc, st.caddr, st.lfsr); // R8
        next_st.caddr = ADDR_W'(st.caddr + 1'b1);
        if (st.caddr == ADDR_W'(TBL_DEPTH - 1)) begin
          next_st.mode = DDS_RUN;
        end
      end
      default: begin
        next_st.mode = DDS_RUN;
      end
    endcase

    // One sample held per converter clock
    if (fifo_out_ready) begin
      next_st.dvalid  = fifo_out_valid; // R5
      next_st.dsample = fifo_out_data;  // R3 R5
    end
  end

  // ****************************************************************
  // State register, local to this channel instance
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st        <= '0;
      st.inc    <= INC_RST;
      st.wave   <= WAVE_RST;
      st.lfsr   <= LFSR_SEED;
      st.mode   <= DDS_RUN;
    end else begin
      st <= next_st; // R11
    end
  end

  assign cur_wave   = st.wave;
  assign set_reject = st.reject;
  assign copy_busy  = (st.mode == DDS_COPY);
  assign dac_valid  = st.dvalid;
  assign dac_sample = st.dsample;

endmodule

`default_nettype wire

// [dv/dds_core_props.sv]
// Port assertions for the synthesis core
`default_nettype none
module dds_core_props
  import dds_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              sys_rst,
  // Settings
  input wire logic              set_load,
  input wire dds_set_t          set_val,
  input wire logic [WAVE_W-1:0] cur_wave,
  input wire logic              set_reject,
  // Copy
  input wire logic              copy_start,
  input wire logic [WAVE_W-1:0] copy_src,
  input wire logic [SEL_W-1:0]  copy_dst,
  input wire logic              copy_busy,
  // Converter
  input wire logic              dac_ready,
  input wire logic              dac_valid,
  input wire logic [SAMP_W-1:0] dac_sample
);
  logic       bad_ld;
  logic       good_cp;
  logic [6:0] busy_len;
  assign bad_ld = set_load && (set_val.wave == 8'h00 || set_val.wave > 8'ha5);
  assign good_cp = copy_start && !copy_busy && copy_src inside {[8'h01:8'h9c]}
                   && copy_dst <= 4'h8;
  // Counts busy cycles so the copy length can be checked past the repetition limit
  always_ff @(posedge core_clk) begin
    if (sys_rst || !copy_busy) begin
      busy_len <= 7'h00;
    end else begin
      busy_len <= busy_len + 7'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wave_load_a: assert property (set_load && !bad_ld |=> cur_wave == $past(set_val.wave))
    else $error("waveform number not taken");
  wave_keep_a: assert property (bad_ld |=> set_reject && $stable(cur_wave))
    else $error("bad waveform number not refused");
  reject_cause_a: assert property (set_reject |-> $past(bad_ld))
    else $error("refusal without bad load");
  out_hold_a: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_sample))
    else $error("sample changed while stalled");
  out_start_a: assert property ($fell(sys_rst) |-> ##2 dac_valid)
    else $error("no sample after reset");
  out_steady_a: assert property (dac_valid |=> dac_valid)
    else $error("sample stream broke off");
  copy_go_a: assert property (good_cp |=> copy_busy)
    else $error("copy did not start");
  copy_len_a: assert property ($fell(copy_busy) |-> busy_len == 7'h40)
    else $error("copy length wrong");
endmodule
bind dds_core dds_core_props u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .set_load(set_load), .set_val(set_val),
  .cur_wave(cur_wave), .set_reject(set_reject), .copy_start(copy_start),
  .copy_src(copy_src), .copy_dst(copy_dst), .copy_busy(copy_busy),
  .dac_ready(dac_ready), .dac_valid(dac_valid), .dac_sample(dac_sample));
`default_nettype wire

// [dv/dds_dac_model.sv]
// Behavioural converter that takes samples from the core
`default_nettype none
module dds_dac_model
  import dds_pkg::*;
(
  // Clock and control
  input  wire logic              core_clk,
  input  wire logic              stall,
  // Sample stream
  input  wire logic              dac_valid,
  input  wire logic [SAMP_W-1:0] dac_sample,
  output logic                   dac_ready,
  // Captured sample
  output logic                   took,
  output logic [SAMP_W-1:0]      took_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    dac_ready = 1'b1;
    took = 1'b0;
  end
  // Random stalls push the core into back-pressure
  always @(posedge core_clk) begin
    took <= dac_valid && dac_ready;
    took_data <= dac_sample;
    dac_ready <= #1 stall ? 1'($urandom % 2) : 1'b1;
  end
endmodule
`default_nettype wire

// [dv/test_dds_core.sv]
// Self-checking bench for the synthesis core
`default_nettype none
module test_dds_core
  import dds_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] STDW [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
  logic              core_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              set_load = 1'b0;
  logic              tbl_we = 1'b0;
  logic              copy_start = 1'b0;
  logic              stall = 1'b0;
  dds_set_t          set_val = '0;
  dds_tbl_wr_t       tbl_wr = '0;
  logic [WAVE_W-1:0] copy_src = 8'h08;
  logic [SEL_W-1:0]  copy_dst = 4'h0;
  logic [WAVE_W-1:0] cur_wave;
  logic              set_reject, copy_busy, dac_ready, dac_valid, took;
  logic [SAMP_W-1:0] dac_sample, took_data;
  logic [11:0]       utbl [9][64];
  int                err_total = 0;
  int                samples_checked = 0;
  always #5 core_clk = ~core_clk;
  dds_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .set_load(set_load),
    .set_val(set_val), .cur_wave(cur_wave), .set_reject(set_reject), .tbl_we(tbl_we),
    .tbl_wr(tbl_wr), .copy_start(copy_start), .copy_src(copy_src), .copy_dst(copy_dst),
    .copy_busy(copy_busy), .dac_ready(dac_ready), .dac_valid(dac_valid),
    .dac_sample(dac_sample));
  dds_dac_model u_dac (.core_clk(core_clk), .stall(stall), .dac_valid(dac_valid),
    .dac_sample(dac_sample), .dac_ready(dac_ready), .took(took), .took_data(took_data));
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [15:0] lfsr_step(input logic [15:0] r);
    return r[0] ? ((r >> 1) ^ LFSR_TAPS) : (r >> 1);
  endfunction
  function automatic logic [11:0] exp_s(input logic [7:0] w, input logic [5:0] a,
                                        input logic [15:0] r);
    logic [13:0] p;
    int          m;
    p = {8'h00, a} * {6'h00, w};
    // Sine halves are parabolas, clipped at 2047 so the top peak is exactly full scale
    m = 8 * int'(a[4:0]) * (32 - int'(a[4:0]));
    if (m > 2047) m = 2047;
    if (w == WAVE_SINE) return a[5] ? SAMP_MID - 12'(m) : SAMP_MID + 12'(m);
    if (w == WAVE_NOISE) return r[11:0];
    if (w == WAVE_PRBS) return r[0] ? 12'hfff : 12'h000;
    if (w == WAVE_SQUARE) return a[5] ? 12'h000 : 12'hfff;
    if (w == WAVE_RAMP) return {a, a};
    if (w == WAVE_PULSE) return a[5:4] == 2'b00 ? 12'hfff : 12'h000;
    if (w == WAVE_DC) return SAMP_MID;
    if (w >= ARB_FIRST) return utbl[w - ARB_FIRST][a];
    return p[11:0] ^ {w, 4'h0};
  endfunction
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (3) tick();
    sys_rst = 1'b0;
    foreach (utbl[i, j]) utbl[i][j] = 12'h000;
    tick();
    chk({4'h0, cur_wave}, {4'h0, WAVE_RST});
  endtask
  // Bit 11 kept clear so a user word never looks like the idle mid-scale sample
  task automatic fill(input logic [3:0] s);
    logic [11:0] d;
    for (int a = 0; a < 64; a++) begin
      d = 12'($urandom) & 12'h7ff;
      tbl_wr = {s, 6'(a), d};
      tbl_we = 1'b1;
      utbl[s][a] = d;
      tick();
    end
    tbl_we = 1'b0;
  endtask
  // Accepted order does not depend on stalls, so the phase walk is predictable
  task automatic run(input logic [7:0] w, input int n);
    logic [31:0] inc, ph;
    logic [15:0] lf;
    int got, lim, seen;
    inc = $urandom;
    ph = '0;
    got = 0;
    lim = 0;
    seen = 0;
    // Two samples are pushed after reset before the new wave reaches the table
    lf = lfsr_step(lfsr_step(LFSR_SEED));
    stall = 1'($urandom % 2);
    set_val = {inc, w};
    set_load = 1'b1;
    tick();
    set_load = 1'b0;
    while (got < n) begin
      tick();
      lim++;
      if (lim > 3000) begin
        err_total++;
        report_and_stop();
      end
      if (took) seen++;
      // Standard runs follow a reset, which leaves exactly two mid-scale samples ahead
      if (took && ((w <= WAVE_PRBS) ? (seen > 2) : (got > 0 || took_data != SAMP_MID))) begin
        chk(took_data, exp_s(w, ph[31:26], lf));
        ph += inc;
        lf = lfsr_step(lf);
        got++;
      end
    end
    $display("wave %0d done", w);
  endtask
  initial begin
    logic [7:0] w;
    logic [3:0] d;
    void'($urandom(32'hb7f193f3));
    do_reset();
    foreach (STDW[i]) begin
      run(STDW[i], 40);
      do_reset();
    end
    for (int i = 0; i < 7; i++) begin
      w = 8'h08 + 8'($urandom % 149);
      if (w == 8'h80) w = 8'h81;
      if (i == 6) break;
      run(w, 40);
      do_reset();
    end
    for (int s = 0; s < 9; s++) begin
      fill(4'(s));
      run(ARB_FIRST + 8'(s), 64);
      do_reset();
    end
    d = 4'($urandom % 9);
    copy_src = w;
    copy_dst = d;
    copy_start = 1'b1;
    tick();
    copy_start = 1'b0;
    tbl_wr = {d, 6'h00, 12'h123};
    tbl_we = 1'b1;
    tick();
    tbl_we = 1'b0;
    chk({11'h000, copy_busy}, 12'h001);
    for (int k = 0; k < 64; k++) utbl[d][k] = exp_s(w, 6'(k), LFSR_SEED);
    for (int k = 0; k < 100 && copy_busy; k++) tick();
    chk({11'h000, copy_busy}, 12'h000);
    if (copy_busy) report_and_stop();
    run(ARB_FIRST + {4'h0, d}, 64);
    set_load = 1'b1;
    for (int i = 0; i < 2; i++) begin
      set_val = {32'($urandom), i == 0 ? 8'h00 : 8'($urandom % 90 + 166)};
      tick();
      chk({11'h000, set_reject}, 12'h001);
      chk({4'h0, cur_wave}, {4'h0, ARB_FIRST + {4'h0, d}});
    end
    set_load = 1'b0;
    $display("refusal test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
